// file: common/dlic_params.svh
// Register map, bit positions and reset values of the interrupt controller
`ifndef DLIC_PARAMS_SVH
`define DLIC_PARAMS_SVH

// Register byte offsets
`define DLIC_OFF_NRM_RAW   8'h00
`define DLIC_OFF_NRM_EN    8'h04
`define DLIC_OFF_NRM_CLR   8'h08
`define DLIC_OFF_NRM_STA   8'h0c
`define DLIC_OFF_FST_RAW   8'h10
`define DLIC_OFF_FST_EN    8'h14
`define DLIC_OFF_FST_CLR   8'h18
`define DLIC_OFF_FST_STA   8'h1c
`define DLIC_OFF_SWI_CFG   8'h20
`define DLIC_OFF_EVT_STAT  8'h24
`define DLIC_OFF_EVT_MASK  8'h28

// Source bit positions
`define DLIC_BIT_OR        0
`define DLIC_BIT_SWI       1
`define DLIC_BIT_SRC_LO    2
`define DLIC_BIT_SRC_HI    24
`define DLIC_BIT_EXT0      15
`define DLIC_BIT_EXT1      18
`define DLIC_BIT_EXT2      21
`define DLIC_BIT_EXT3      22

// Programmed interrupt config bits
`define DLIC_SWI_NRM       1
`define DLIC_SWI_FST       2
`define DLIC_SWI_WMASK     32'h0000_0006

// Writable enable bits: maskable sources only
`define DLIC_EN_WMASK      32'h01ff_fffc
// Bits 1 and 0 pass the mask unconditionally
`define DLIC_EN_FORCED     32'h0000_0003

// Event status bits
`define DLIC_EVT_NRM       0
`define DLIC_EVT_FST       1

// Reset values
`define DLIC_RST_WORD      32'h0000_0000
`define DLIC_RST_EVT       2'h0

// AXI responses
`define DLIC_RESP_OKAY     2'h0
`define DLIC_RESP_SLVERR   2'h2

`endif

// file: common/dlic_pkg.sv
// Types shared by the interrupt controller and its bench
package dlic_pkg;

   typedef logic [31:0] dlic_word_t;
   typedef logic [7:0]  dlic_addr_t;
   typedef logic [3:0]  dlic_strb_t;
   typedef logic [3:0]  dlic_ext_t;
   typedef logic [22:0] dlic_src_t;
   typedef logic [1:0]  dlic_resp_t;

   // Captured write request
   typedef struct packed {
      dlic_addr_t addr;
      dlic_word_t data;
      dlic_strb_t strb;
   } dlic_wr_t;

endpackage

// file: src/dlic_top.sv
// Dual-level interrupt controller with AXI4-Lite register slave
`timescale 1ns/1ps
`include "dlic_params.svh"

module dlic_top
(
   // Clock and reset
   input  wire logic               i_mclk,
   input  wire logic               i_rst,
   // Interrupt sources
   input  wire dlic_pkg::dlic_src_t i_periph_req,
   input  wire dlic_pkg::dlic_ext_t i_ext_req,
   // Requests to the core
   output logic                    o_irq,
   output logic                    o_fiq,
   output logic                    o_evt_int,
   // AXI4-Lite write address
   input  wire logic               i_s_axi_awvalid,
   output logic                    o_s_axi_awready,
   input  wire dlic_pkg::dlic_addr_t i_s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic               i_s_axi_wvalid,
   output logic                    o_s_axi_wready,
   input  wire dlic_pkg::dlic_word_t i_s_axi_wdata,
   input  wire dlic_pkg::dlic_strb_t i_s_axi_wstrb,
   // AXI4-Lite write response
   output logic                    o_s_axi_bvalid,
   input  wire logic               i_s_axi_bready,
   output dlic_pkg::dlic_resp_t    o_s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic               i_s_axi_arvalid,
   output logic                    o_s_axi_arready,
   input  wire dlic_pkg::dlic_addr_t i_s_axi_araddr,
   // AXI4-Lite read data
   output logic                    o_s_axi_rvalid,
   input  wire logic               i_s_axi_rready,
   output dlic_pkg::dlic_word_t    o_s_axi_rdata,
   output dlic_pkg::dlic_resp_t    o_s_axi_rresp
);
   import dlic_pkg::*;

   // Address is one of the mapped registers
   function automatic logic addr_mapped(input dlic_addr_t a);
      logic hit;
      hit = 1'b0;
      if (a == `DLIC_OFF_NRM_RAW || a == `DLIC_OFF_NRM_EN ||
          a == `DLIC_OFF_NRM_CLR || a == `DLIC_OFF_NRM_STA)
         hit = 1'b1;
      else if (a == `DLIC_OFF_FST_RAW || a == `DLIC_OFF_FST_EN ||
               a == `DLIC_OFF_FST_CLR || a == `DLIC_OFF_FST_STA)
         hit = 1'b1;
      else if (a == `DLIC_OFF_SWI_CFG || a == `DLIC_OFF_EVT_STAT ||
               a == `DLIC_OFF_EVT_MASK)
         hit = 1'b1;
      return hit;
   endfunction

   // Byte strobes to a bit mask
   function automatic dlic_word_t strb_mask(input dlic_strb_t s);
      dlic_word_t m;
      m = `DLIC_RST_WORD;
      for (int i = 0; i < 4; i++)
         m[i*8 +: 8] = {8{s[i]}};
      return m;
   endfunction

   // External pins are asynchronous: two flops before use
   dlic_ext_t   ext_meta_reg;
   dlic_ext_t   ext_sync_reg;
   dlic_word_t  src_reg;
   dlic_word_t  src_next;
   dlic_word_t  nrm_en_reg;
   dlic_word_t  fst_en_reg;
   dlic_word_t  swi_reg;
   logic [1:0]  evt_stat_reg;
   logic [1:0]  evt_mask_reg;
   logic        o_irq_reg;
   logic        o_fiq_reg;
   logic        o_evt_int_reg;

   dlic_word_t  nrm_raw;
   dlic_word_t  fst_raw;
   dlic_word_t  nrm_sta;
   dlic_word_t  fst_sta;
   logic        fiq_or;
   logic        irq_or;

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         ext_meta_reg <= 4'h0;
         ext_sync_reg <= 4'h0;
      end
      else
      begin
         ext_meta_reg <= i_ext_req;
         ext_sync_reg <= ext_meta_reg;
      end
   end

   // Place peripheral lines and pins at their fixed bit positions
   always_comb
   begin
      src_next = `DLIC_RST_WORD;
      src_next[`DLIC_BIT_SRC_HI:`DLIC_BIT_SRC_LO] = i_periph_req;
      src_next[`DLIC_BIT_EXT0] = ext_sync_reg[0];
      src_next[`DLIC_BIT_EXT1] = ext_sync_reg[1];
      src_next[`DLIC_BIT_EXT2] = ext_sync_reg[2];
      src_next[`DLIC_BIT_EXT3] = ext_sync_reg[3];
   end

   // Level sampling, no latching: a dropped request vanishes
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         src_reg <= `DLIC_RST_WORD;
      else
         src_reg <= src_next;
   end

   // Status vectors; no encoder, software scans them
   always_comb
   begin
      fst_raw = src_reg;
      fst_raw[`DLIC_BIT_SWI] = swi_reg[`DLIC_SWI_FST];
      fst_sta = fst_raw & (fst_en_reg | `DLIC_EN_FORCED);
      fiq_or  = |fst_sta[31:1];
      fst_raw[`DLIC_BIT_OR] = fiq_or;
      fst_sta[`DLIC_BIT_OR] = fiq_or;
      nrm_raw = src_reg;
      nrm_raw[`DLIC_BIT_SWI] = swi_reg[`DLIC_SWI_NRM];
      nrm_raw[`DLIC_BIT_OR]  = fiq_or;
      nrm_sta = nrm_raw & (nrm_en_reg | `DLIC_EN_FORCED);
      irq_or  = |nrm_sta;
   end

   // ---------------- AXI4-Lite slave ----------------
   logic        aw_full_reg;
   logic        w_full_reg;
   dlic_wr_t    wr_reg;
   logic        bvalid_reg;
   dlic_resp_t  bresp_reg;
   logic        rvalid_reg;
   dlic_word_t  rdata_reg;
   dlic_resp_t  rresp_reg;
   logic        wr_go;
   dlic_word_t  wmask;
   dlic_word_t  wbits;
   dlic_word_t  rd_next;

   assign o_s_axi_awready = !aw_full_reg;
   assign o_s_axi_wready  = !w_full_reg;
   assign o_s_axi_arready = !rvalid_reg;
   assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wmask = strb_mask(wr_reg.strb);
   assign wbits = wr_reg.data & wmask;

   // Address and data may arrive in either order
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         wr_reg      <= '0;
      end
      else
      begin
         if (i_s_axi_awvalid && !aw_full_reg)
         begin
            aw_full_reg <= 1'b1;
            wr_reg.addr <= i_s_axi_awaddr;
         end
         else if (wr_go)
            aw_full_reg <= 1'b0;
         if (i_s_axi_wvalid && !w_full_reg)
         begin
            w_full_reg  <= 1'b1;
            wr_reg.data <= i_s_axi_wdata;
            wr_reg.strb <= i_s_axi_wstrb;
         end
         else if (wr_go)
            w_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= `DLIC_RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= addr_mapped(wr_reg.addr) ? `DLIC_RESP_OKAY
                                                : `DLIC_RESP_SLVERR;
      end
      else if (i_s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   // Enable masks: set-only writes avoid read-modify-write races
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         nrm_en_reg <= `DLIC_RST_WORD;
         fst_en_reg <= `DLIC_RST_WORD;
      end
      else if (wr_go)
      begin
         if (wr_reg.addr == `DLIC_OFF_NRM_EN)
         begin
            nrm_en_reg <= nrm_en_reg | (wbits & `DLIC_EN_WMASK);
            fst_en_reg <= fst_en_reg & ~(wbits & `DLIC_EN_WMASK);
         end
         else if (wr_reg.addr == `DLIC_OFF_FST_EN)
         begin
            fst_en_reg <= fst_en_reg | (wbits & `DLIC_EN_WMASK);
            nrm_en_reg <= nrm_en_reg & ~(wbits & `DLIC_EN_WMASK);
         end
         else if (wr_reg.addr == `DLIC_OFF_NRM_CLR)
            nrm_en_reg <= nrm_en_reg & ~(wbits & `DLIC_EN_WMASK);
         else if (wr_reg.addr == `DLIC_OFF_FST_CLR)
            fst_en_reg <= fst_en_reg & ~(wbits & `DLIC_EN_WMASK);
      end
   end

   // Programmed interrupt config; reserved bits stay zero
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         swi_reg <= `DLIC_RST_WORD;
      else if (wr_go && wr_reg.addr == `DLIC_OFF_SWI_CFG)
         swi_reg <= ((swi_reg & ~wmask) | wbits) & `DLIC_SWI_WMASK;
   end

   // Event flags: rising edge of each request, write one to clear
   logic [1:0] evt_set;
   logic [1:0] evt_clr;
   assign evt_set = {fiq_or & !o_fiq_reg, irq_or & !o_irq_reg};
   assign evt_clr = (wr_go && wr_reg.addr == `DLIC_OFF_EVT_STAT)
                    ? wbits[1:0] : `DLIC_RST_EVT;

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         evt_stat_reg <= `DLIC_RST_EVT;
         evt_mask_reg <= `DLIC_RST_EVT;
      end
      else
      begin
         // Set wins over a same-cycle clear
         evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
         if (wr_go && wr_reg.addr == `DLIC_OFF_EVT_MASK)
            evt_mask_reg <= (evt_mask_reg & ~wmask[1:0]) | wbits[1:0];
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_irq_reg     <= 1'b0;
         o_fiq_reg     <= 1'b0;
         o_evt_int_reg <= 1'b0;
      end
      else
      begin
         o_irq_reg     <= irq_or;
         o_fiq_reg     <= fiq_or;
         o_evt_int_reg <= |(evt_stat_reg & evt_mask_reg);
      end
   end

   // Read mux; clear registers are write-only and read zero
   always_comb
   begin
      rd_next = `DLIC_RST_WORD;
      if (i_s_axi_araddr == `DLIC_OFF_NRM_RAW)
         rd_next = nrm_raw;
      else if (i_s_axi_araddr == `DLIC_OFF_NRM_EN)
         rd_next = nrm_en_reg;
      else if (i_s_axi_araddr == `DLIC_OFF_NRM_STA)
         rd_next = nrm_sta;
      else if (i_s_axi_araddr == `DLIC_OFF_FST_RAW)
         rd_next = fst_raw;
      else if (i_s_axi_araddr == `DLIC_OFF_FST_EN)
         rd_next = fst_en_reg;
      else if (i_s_axi_araddr == `DLIC_OFF_FST_STA)
         rd_next = fst_sta;
      else if (i_s_axi_araddr == `DLIC_OFF_SWI_CFG)
         rd_next = swi_reg;
      else if (i_s_axi_araddr == `DLIC_OFF_EVT_STAT)
         rd_next[1:0] = evt_stat_reg;
      else if (i_s_axi_araddr == `DLIC_OFF_EVT_MASK)
         rd_next[1:0] = evt_mask_reg;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= `DLIC_RST_WORD;
         rresp_reg  <= `DLIC_RESP_OKAY;
      end
      else if (i_s_axi_arvalid && !rvalid_reg)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_next;
         rresp_reg  <= addr_mapped(i_s_axi_araddr) ? `DLIC_RESP_OKAY
                                                   : `DLIC_RESP_SLVERR;
      end
      else if (i_s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   assign o_s_axi_bvalid = bvalid_reg;
   assign o_s_axi_bresp  = bresp_reg;
   assign o_s_axi_rvalid = rvalid_reg;
   assign o_s_axi_rdata  = rdata_reg;
   assign o_s_axi_rresp  = rresp_reg;
   assign o_irq          = o_irq_reg;
   assign o_fiq          = o_fiq_reg;
   assign o_evt_int      = o_evt_int_reg;

   // ---------------- Checks ----------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   // Checked against the input pins, not the internal next value
   src_position_a: assert property
      (##1 (src_reg[`DLIC_BIT_SRC_LO] == $past(i_periph_req[0]) &&
            src_reg[`DLIC_BIT_SRC_HI] == $past(i_periph_req[22])))
      else $error("source bit moved from its position");
   ext_pin_a: assert property
      ($rose(i_ext_req[0]) ##1 i_ext_req[0] ##1 i_ext_req[0]
       |=> nrm_raw[`DLIC_BIT_EXT0])
      else $error("external pin not seen in raw status");
   irq_out_a: assert property
      (|nrm_sta |=> o_irq)
      else $error("normal request missing");
   irq_idle_a: assert property
      ((nrm_en_reg[`DLIC_BIT_SRC_HI:`DLIC_BIT_SRC_LO] == '0) &&
       !swi_reg[`DLIC_SWI_NRM] && !fiq_or |=> !o_irq)
      else $error("normal request with all sources masked");
   fiq_out_a: assert property
      (o_fiq == $past(|fst_sta[31:1]) && nrm_raw[0] == fiq_or)
      else $error("fast request or bit 0 mismatch");
   one_level_a: assert property
      ((nrm_en_reg & fst_en_reg) == '0)
      else $error("source enabled at both levels");
   clear_en_a: assert property
      (wr_go && wr_reg.addr == `DLIC_OFF_NRM_CLR && wbits[5]
       |=> !nrm_en_reg[5])
      else $error("mask clear did not clear");
   set_keep_a: assert property
      (wr_go && wr_reg.addr == `DLIC_OFF_NRM_EN && !wbits[7]
       |=> nrm_en_reg[7] == $past(nrm_en_reg[7]))
      else $error("enable write disturbed a zero bit");
   swi_nomask_a: assert property
      (swi_reg[`DLIC_SWI_NRM] |-> nrm_sta[`DLIC_BIT_SWI] ##1 o_irq)
      else $error("programmed interrupt was masked");
   swi_fast_a: assert property
      (swi_reg[`DLIC_SWI_FST] |-> fst_sta[`DLIC_BIT_SWI] ##1 o_fiq)
      else $error("programmed fast interrupt missing");
   bresp_time_a: assert property
      (wr_go |=> o_s_axi_bvalid)
      else $error("write response late");

   irq_seen_c: cover property ($rose(o_irq));
   fiq_seen_c: cover property ($rose(o_fiq) ##1 o_irq);
   evt_int_c:  cover property ($rose(o_evt_int));
   slverr_c:   cover property (o_s_axi_rvalid &&
                               o_s_axi_rresp == `DLIC_RESP_SLVERR);

endmodule

// file: tb/dlic_core_model.sv
// Behavioural processor core counting normal and fast exception entries
`timescale 1ns/1ps

module dlic_core_model
(
   // Clock and reset
   input  wire logic i_mclk,
   input  wire logic i_rst,
   // Requests from the controller
   input  wire logic i_irq,
   input  wire logic i_fiq,
   // Exception entry counts
   output logic [7:0] o_irq_cnt,
   output logic [7:0] o_fiq_cnt
);
   logic irq_reg;
   logic fiq_reg;

   // Entry only on a new request; a held level is one exception, not many
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         irq_reg   <= 1'b0;
         fiq_reg   <= 1'b0;
         o_irq_cnt <= 8'h00;
         o_fiq_cnt <= 8'h00;
      end
      else
      begin
         irq_reg <= i_irq;
         fiq_reg <= i_fiq;
         if (i_irq && !irq_reg)
            o_irq_cnt <= o_irq_cnt + 8'h01;
         if (i_fiq && !fiq_reg)
            o_fiq_cnt <= o_fiq_cnt + 8'h01;
      end
   end
endmodule

// file: tb/dlic_top_tb.sv
// Self-checking bench for the dual-level interrupt controller
`timescale 1ns/1ps
`include "dlic_params.svh"

module dlic_top_tb;
   import dlic_pkg::*;

   logic       i_mclk;
   logic       i_rst;
   dlic_src_t  preq;
   dlic_ext_t  ereq;
   logic       o_irq;
   logic       o_fiq;
   logic       o_evt_int;
   logic       awvalid;
   logic       awready;
   dlic_addr_t awaddr;
   logic       wvalid;
   logic       wready;
   dlic_word_t wdata;
   dlic_strb_t wstrb;
   logic       bvalid;
   logic       bready;
   dlic_resp_t bresp;
   logic       arvalid;
   logic       arready;
   dlic_addr_t araddr;
   logic       rvalid;
   logic       rready;
   dlic_word_t rdata;
   dlic_resp_t rresp;
   logic [7:0] irq_cnt;
   logic [7:0] fiq_cnt;
   logic [7:0] fiq_before;
   logic [7:0] irq_before;
   dlic_resp_t rsp;
   int         n_fail;
   int         check_count;
   int         k;
   int         ext_bit [4] = '{15, 18, 21, 22};

   dlic_top dut
   (
      .i_mclk          (i_mclk),
      .i_rst           (i_rst),
      .i_periph_req    (preq),
      .i_ext_req       (ereq),
      .o_irq           (o_irq),
      .o_fiq           (o_fiq),
      .o_evt_int       (o_evt_int),
      .i_s_axi_awvalid (awvalid),
      .o_s_axi_awready (awready),
      .i_s_axi_awaddr  (awaddr),
      .i_s_axi_wvalid  (wvalid),
      .o_s_axi_wready  (wready),
      .i_s_axi_wdata   (wdata),
      .i_s_axi_wstrb   (wstrb),
      .o_s_axi_bvalid  (bvalid),
      .i_s_axi_bready  (bready),
      .o_s_axi_bresp   (bresp),
      .i_s_axi_arvalid (arvalid),
      .o_s_axi_arready (arready),
      .i_s_axi_araddr  (araddr),
      .o_s_axi_rvalid  (rvalid),
      .i_s_axi_rready  (rready),
      .o_s_axi_rdata   (rdata),
      .o_s_axi_rresp   (rresp)
   );

   dlic_core_model core
   (
      .i_mclk    (i_mclk),
      .i_rst     (i_rst),
      .i_irq     (o_irq),
      .i_fiq     (o_fiq),
      .o_irq_cnt (irq_cnt),
      .o_fiq_cnt (fiq_cnt)
   );

   always #20 i_mclk = ~i_mclk;

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input dlic_word_t e,
                      input dlic_word_t g);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge i_mclk);
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr_s(input dlic_addr_t a, input dlic_word_t d,
                       input dlic_strb_t s, input dlic_resp_t e);
      @(posedge i_mclk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      bready  <= 1'b1;
      do
      begin
         @(posedge i_mclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
      chk("write resp", {30'h0, e}, {30'h0, rsp});
   endtask

   task automatic wr(input dlic_addr_t a, input dlic_word_t d);
      wr_s(a, d, 4'hf, `DLIC_RESP_OKAY);
   endtask

   task automatic rd_r(input dlic_addr_t a, input dlic_word_t e,
                       input dlic_resp_t er, input string nm);
      @(posedge i_mclk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      do
      begin
         @(posedge i_mclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      chk(nm, e, rdata);
      chk({nm, " resp"}, {30'h0, er}, {30'h0, rresp});
      rready <= 1'b0;
   endtask

   task automatic rd(input dlic_addr_t a, input dlic_word_t e,
                     input string nm);
      rd_r(a, e, `DLIC_RESP_OKAY, nm);
   endtask

   task automatic pins(input logic ei, input logic ef);
      chk("irq out", {31'h0, ei}, {31'h0, o_irq});
      chk("fiq out", {31'h0, ef}, {31'h0, o_fiq});
   endtask

   // Generous bound: the sequence needs well under 3000 cycles
   initial
   begin
      wt(20000);
      n_fail++;
      summarize();
   end

   initial
   begin
      i_mclk  = 1'b0;
      i_rst   = 1'b1;
      preq    = '0;
      ereq    = '0;
      awvalid = 1'b0;
      awaddr  = '0;
      wvalid  = 1'b0;
      wdata   = '0;
      wstrb   = 4'hf;
      bready  = 1'b0;
      arvalid = 1'b0;
      araddr  = '0;
      rready  = 1'b0;
      wt(10);
      i_rst <= 1'b0;
      for (k = 0; k < 11; k++)
         rd(8'(4 * k), 32'h0, "reset value");
      pins(1'b0, 1'b0);
      rd_r(8'h2c, 32'h0, `DLIC_RESP_SLVERR, "unmapped");
      wr_s(8'h30, 32'hffff_ffff, 4'hf, `DLIC_RESP_SLVERR);
      // Sources held far beyond the one-cycle sampling delay of src_reg
      preq <= 23'h000003;
      wt(4);
      rd(`DLIC_OFF_NRM_RAW, 32'h0000_000c, "nrm raw");
      rd(`DLIC_OFF_FST_RAW, 32'h0000_000c, "fst raw");
      wr(`DLIC_OFF_NRM_RAW, 32'h0);
      rd(`DLIC_OFF_NRM_RAW, 32'h0000_000c, "raw ro");
      rd(`DLIC_OFF_NRM_STA, 32'h0, "nrm sta off");
      pins(1'b0, 1'b0);
      wr(`DLIC_OFF_NRM_EN, 32'h0000_0004);
      wt(3);
      pins(1'b1, 1'b0);
      wr(`DLIC_OFF_NRM_EN, 32'h0000_0008);
      rd(`DLIC_OFF_NRM_EN, 32'h0000_000c, "nrm en set");
      rd(`DLIC_OFF_NRM_STA, 32'h0000_000c, "nrm sta");
      wr(`DLIC_OFF_NRM_CLR, 32'h0000_0004);
      rd(`DLIC_OFF_NRM_EN, 32'h0000_0008, "nrm clr");
      rd(`DLIC_OFF_NRM_CLR, 32'h0, "clr reads");
      wr(`DLIC_OFF_FST_EN, 32'h0000_0008);
      rd(`DLIC_OFF_NRM_EN, 32'h0, "fst wins");
      rd(`DLIC_OFF_FST_STA, 32'h0000_0009, "fst sta");
      rd(`DLIC_OFF_NRM_STA, 32'h0000_0001, "nrm bit0");
      pins(1'b1, 1'b1);
      wr(`DLIC_OFF_NRM_EN, 32'h0000_0008);
      rd(`DLIC_OFF_FST_EN, 32'h0, "nrm wins");
      wt(3);
      pins(1'b1, 1'b0);
      wr(`DLIC_OFF_NRM_CLR, 32'h0000_0008);
      rd(`DLIC_OFF_NRM_EN, 32'h0, "both off nrm");
      rd(`DLIC_OFF_FST_EN, 32'h0, "both off fst");
      wt(3);
      pins(1'b0, 1'b0);
      wr_s(`DLIC_OFF_NRM_EN, 32'hffff_ffff, 4'h1, `DLIC_RESP_OKAY);
      rd(`DLIC_OFF_NRM_EN, 32'h0000_00fc, "lane 0");
      wr(`DLIC_OFF_NRM_CLR, 32'hffff_ffff);
      wr(`DLIC_OFF_FST_EN, 32'hffff_ffff);
      rd(`DLIC_OFF_FST_EN, 32'h01ff_fffc, "fst en all");
      rd(`DLIC_OFF_NRM_EN, 32'h0, "nrm en gone");
      rd(`DLIC_OFF_FST_STA, 32'h0000_000d, "fst sta all");
      wr(`DLIC_OFF_FST_CLR, 32'hffff_ffff);
      rd(`DLIC_OFF_FST_EN, 32'h0, "fst clr");
      preq <= '0;
      wt(4);
      rd(`DLIC_OFF_NRM_RAW, 32'h0, "raw follows");
      // External pins, each through its own bit position
      wr(`DLIC_OFF_NRM_EN, 32'h01ff_fffc);
      for (k = 0; k < 4; k++)
      begin
         ereq <= 4'(1 << k);
         wt(6);
         rd(`DLIC_OFF_NRM_STA, 32'h1 << ext_bit[k], "ext pin");
         pins(1'b1, 1'b0);
      end
      ereq <= '0;
      wr(`DLIC_OFF_NRM_CLR, 32'hffff_ffff);
      wt(6);
      pins(1'b0, 1'b0);
      // Event flags: clear, unmask normal, raise programmed request
      wr(`DLIC_OFF_EVT_STAT, 32'h0000_0003);
      wr(`DLIC_OFF_EVT_MASK, 32'h0000_0001);
      rd(`DLIC_OFF_EVT_STAT, 32'h0, "evt cleared");
      irq_before = irq_cnt;
      wr(`DLIC_OFF_SWI_CFG, 32'h0000_0002);
      rd(`DLIC_OFF_NRM_RAW, 32'h0000_0002, "swi raw");
      rd(`DLIC_OFF_NRM_STA, 32'h0000_0002, "swi sta");
      pins(1'b1, 1'b0);
      chk("irq entries", 32'(irq_before) + 1, 32'(irq_cnt));
      // Clearing bit 1 must leave the programmed request standing
      wr(`DLIC_OFF_NRM_CLR, 32'h0000_0002);
      rd(`DLIC_OFF_NRM_STA, 32'h0000_0002, "swi clr");
      rd(`DLIC_OFF_EVT_STAT, 32'h0000_0001, "evt nrm");
      chk("evt int", 32'h1, {31'h0, o_evt_int});
      wr(`DLIC_OFF_EVT_MASK, 32'h0);
      wt(3);
      chk("evt masked", 32'h0, {31'h0, o_evt_int});
      wr(`DLIC_OFF_EVT_STAT, 32'h0000_0001);
      rd(`DLIC_OFF_EVT_STAT, 32'h0, "evt w1c");
      wr(`DLIC_OFF_SWI_CFG, 32'h0);
      wt(3);
      pins(1'b0, 1'b0);
      fiq_before = fiq_cnt;
      wr(`DLIC_OFF_SWI_CFG, 32'h0000_0004);
      rd(`DLIC_OFF_FST_RAW, 32'h0000_0003, "swi fst raw");
      rd(`DLIC_OFF_FST_STA, 32'h0000_0003, "swi fst sta");
      rd(`DLIC_OFF_NRM_RAW, 32'h0000_0001, "swi nrm raw");
      pins(1'b1, 1'b1);
      chk("fiq entries", 32'(fiq_before) + 1, 32'(fiq_cnt));
      rd(`DLIC_OFF_EVT_STAT, 32'h0000_0003, "evt both");
      wr(`DLIC_OFF_SWI_CFG, 32'hffff_ffff);
      rd(`DLIC_OFF_SWI_CFG, 32'h0000_0006, "swi cfg rsvd");
      wr(`DLIC_OFF_SWI_CFG, 32'h0);
      wt(3);
      pins(1'b0, 1'b0);
      summarize();
   end
endmodule
